// ==== hdl/eewc_top.sv ====
// edge event wakeup controller: edge capture, masks, pending and wakeup
`timescale 1ns/100ps
`include "eewc_regs.svh"

module eewc_top
  import eewc_pkg::*;
#(
  parameter int GPIO_PINS = `EEWC_GPIO_PINS
) (
  input  wire logic                                sys_clk_i,             // system clock, 100 MHz
  input  wire logic                                rst_i,                 // reset, active high: synchronous for state, asynchronous for pin toggles
  input  wire logic [GPIO_PINS-1:0]                gpio_pin_i,            // raw GPIO pins
  input  wire logic [`EEWC_EXT_LINES-1:0][`EEWC_SEL_W-1:0] line_sel_i,    // pin picked by each external line
  input  wire logic                                rtc_wake_i,            // real-time clock source
  input  wire logic                                two_wire_port_one_i,   // two-wire port source
  input  wire logic                                serial_port_one_i,     // first serial source
  input  wire logic                                serial_port_two_i,     // second serial source
  input  wire logic                                usb_wake_i,            // usb source
  input  wire logic [1:0]                          analog_comparators_i,  // comparator outputs
  input  wire logic                                secondary_io_supply_i, // supply comparator
  input  wire logic                                cec_wake_i,            // consumer control source
  input  wire logic [`EEWC_SPARE_W-1:0]            spare_wake_i,          // unused internal lines
  input  wire logic [`EEWC_NUM_LINES-1:0]          rise_en_i,             // rising edge triggers line
  input  wire logic [`EEWC_NUM_LINES-1:0]          fall_en_i,             // falling edge triggers line
  input  wire logic [`EEWC_NUM_LINES-1:0]          int_en_i,              // interrupt unmask per line
  input  wire logic [`EEWC_NUM_LINES-1:0]          evt_en_i,              // event unmask per line
  input  wire logic [`EEWC_NUM_LINES-1:0]          pend_clr_i,            // write-one-to-clear pulse
  output logic      [`EEWC_NUM_LINES-1:0]          pending_o,             // pending requests
  output logic                                     irq_o,                 // any pending request
  output logic                                     evt_o,                 // one-cycle event pulse
  output logic                                     wakeup_o               // wakeup to power control
);

  // all system-clock state sits in one struct, so reset clears it in one place
  eewc_state_s q;        // registered state
  eewc_state_s d;        // next state
  eewc_ext_t   ext_line; // selected pin per external line
  eewc_ext_t   rise_tog; // toggles on each rising pin edge
  eewc_ext_t   fall_tog; // toggles on each falling pin edge
  eewc_int_t   int_src;  // internal source levels
  eewc_line_t  trig_c;   // lines that fired this cycle

  // pick one pin out of the pin vector, out-of-range picks read low
  function automatic logic pin_pick(input logic [GPIO_PINS-1:0] pins, input logic [`EEWC_SEL_W-1:0] sel);
    logic r;
    r = 1'b0;
    if (int'(sel) < GPIO_PINS) begin
      r = pins[sel];
    end
    return r;
  endfunction

  // internal line map
  // the peripherals run on the system clock, so they need no sync stages
  // peripheral wakeup sources
  assign int_src = {spare_wake_i, cec_wake_i, secondary_io_supply_i, analog_comparators_i,
                    usb_wake_i, serial_port_two_i, serial_port_one_i, two_wire_port_one_i, rtc_wake_i};

  // per external line: pin mux and edge capture on the line itself
  genvar g;
  generate
    for (g = 0; g < `EEWC_EXT_LINES; g++) begin : g_ext
      logic rise_t; // flips on each rising edge of the picked pin
      logic fall_t; // flips on each falling edge of the picked pin
      assign ext_line[g] = pin_pick(gpio_pin_i, line_sel_i[g]);
      // no system clock needed
      // change line_sel_i only with the line masked: a mux switch can fake an edge
      always_ff @(posedge ext_line[g] or posedge rst_i) begin
        if (rst_i) begin
          rise_t <= 1'b0;
        end else begin
          rise_t <= ~rise_t;
        end
      end
      // falling edges use their own toggle so a pulse gives both edges
      always_ff @(negedge ext_line[g] or posedge rst_i) begin
        if (rst_i) begin
          fall_t <= 1'b0;
        end else begin
          fall_t <= ~fall_t;
        end
      end
      // each toggle has one writer; the vectors only gather them
      assign rise_tog[g] = rise_t;
      assign fall_tog[g] = fall_t;
    end
  endgenerate

  // trigger decode: toggle change for external, level change for internal
  // a toggle that differs from its handled copy means an edge arrived
  // separate rising and falling choice
  assign trig_c = {(int_src & ~q.int_prev & rise_en_i[`EEWC_NUM_LINES-1:`EEWC_EXT_LINES]) |
                   (~int_src & q.int_prev & fall_en_i[`EEWC_NUM_LINES-1:`EEWC_EXT_LINES]),
                   ((q.rise_s2 ^ q.rise_seen) & rise_en_i[`EEWC_EXT_LINES-1:0]) |
                   ((q.fall_s2 ^ q.fall_seen) & fall_en_i[`EEWC_EXT_LINES-1:0])};

  // next state
  always_comb begin
    d = q;
    // toggle crossing: two stages, only the second is compared
    d.rise_s1   = rise_tog;
    d.rise_s2   = q.rise_s1;
    d.fall_s1   = fall_tog;
    d.fall_s2   = q.fall_s1;
    // an edge seen while disabled is consumed and forgotten
    d.rise_seen = q.rise_s2;
    d.fall_seen = q.fall_s2;
    d.int_prev  = int_src;
    // write one clears, a new trigger wins
    d.pend      = (q.pend & ~pend_clr_i) | (trig_c & int_en_i);
    d.irq       = |d.pend;
    // event is a pulse, it needs no clear
    d.evt       = |(trig_c & evt_en_i);
    // any interrupt- or event-enabled trigger or outstanding request wakes
    d.wake      = (|d.pend) | d.evt;
    // synchronous reset last, so it overrides every field above
    if (rst_i) begin
      d = '0;
    end
  end

  // state register
  // no reset branch here: the reset sits in the next-state logic
  always_ff @(posedge sys_clk_i) begin
    q <= d;
  end

  // outputs straight from the register
  assign pending_o = q.pend;
  assign irq_o     = q.irq;
  assign evt_o     = q.evt;
  assign wakeup_o  = q.wake;

  // checks
  // the toggles move between clock edges, so checks on them look only at
  // the sampled toggle level and leave room for both sync stages
  // and the output register behind them

  // reset must leave nothing pending behind, whatever the pins did
  a_reset_empty: assert property (@(posedge sys_clk_i)
    $fell(rst_i) |-> (pending_o == '0) && !irq_o && !evt_o && !wakeup_o)
    else $error("outputs not empty after reset");

  a_pend_on_trig: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ((trig_c & int_en_i) != '0) |=> ((pending_o & $past(trig_c) & $past(int_en_i)) == ($past(trig_c) & $past(int_en_i))))
    else $error("enabled trigger did not set pending");

  a_mask_blocks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    1'b1 |=> ((pending_o & ~$past(pending_o) & ~$past(int_en_i)) == '0))
    else $error("masked line set pending");

  a_no_spurious: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    1'b1 |=> ((pending_o & ~$past(pending_o) & ~$past(trig_c)) == '0))
    else $error("pending set without trigger");

  a_clear_works: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (pend_clr_i != '0) |=> ((pending_o & $past(pend_clr_i) & ~$past(trig_c)) == '0))
    else $error("pending not cleared");

  a_pend_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (pending_o != '0) |=> ((~pending_o & $past(pending_o) & ~$past(pend_clr_i)) == '0))
    else $error("pending dropped without clear");

  a_irq_tracks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    irq_o == (pending_o != '0))
    else $error("interrupt disagrees with pending");

  a_evt_cause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ((trig_c & evt_en_i) != '0) |=> evt_o)
    else $error("event pulse missing");

  // an event pulse needs an event-enabled trigger one cycle before
  a_evt_only_trig: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    evt_o |-> $past((trig_c & evt_en_i) != '0))
    else $error("event pulse without enabled trigger");

  a_wake_follows: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (trig_c != '0) && ((trig_c & (int_en_i | evt_en_i)) != '0) |=> wakeup_o)
    else $error("wakeup missing after trigger");

  // wakeup never rises on its own
  a_wake_needs_cause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(wakeup_o) |-> $past(trig_c != '0))
    else $error("wakeup without trigger");

  // rising edge on line 3, the line that carries the narrow pin pulse
  a_ext_latency: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $changed(rise_tog[3]) && rise_en_i[3] && int_en_i[3] && !pend_clr_i[3] |-> ##[1:4] pending_o[3])
    else $error("external rising edge lost");

  // falling edge on line 0, taken while the system clock was halted
  a_ext_fall_latency: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $changed(fall_tog[0]) && fall_en_i[0] && int_en_i[0] && !pend_clr_i[0] |-> ##[1:4] pending_o[0])
    else $error("external falling edge lost");

  // main scenarios: pin line, peripheral line, clear race, event, wakeup
  c_ext_pending: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(pending_o[0]));
  c_int_pending: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(pending_o[17]));
  c_set_and_clear: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    ((pend_clr_i & trig_c & int_en_i) != '0));
  c_event: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    evt_o);
  c_stop_wake: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(wakeup_o));

endmodule

// ==== hdl/eewc_regs.svh ====
// constants of the edge event wakeup controller
`ifndef EEWC_REGS_SVH
`define EEWC_REGS_SVH
`define EEWC_NUM_LINES   32
`define EEWC_EXT_LINES   16
`define EEWC_INT_LINES   16
`define EEWC_GPIO_PINS   86
`define EEWC_SEL_W       7
// internal line positions, counted from the first internal line
`define EEWC_LN_RTC      0
`define EEWC_LN_TWP1     1
`define EEWC_LN_SER1     2
`define EEWC_LN_SER2     3
`define EEWC_LN_USB      4
`define EEWC_LN_CMP0     5
`define EEWC_LN_CMP1     6
`define EEWC_LN_SIOS     7
`define EEWC_LN_CEC      8
`define EEWC_LN_SPARE    9
`define EEWC_SPARE_W     7
`endif

// ==== hdl/eewc_pkg.sv ====
// types of the edge event wakeup controller
`include "eewc_regs.svh"
package eewc_pkg;
  typedef logic [`EEWC_NUM_LINES-1:0] eewc_line_t;
  typedef logic [`EEWC_EXT_LINES-1:0] eewc_ext_t;
  typedef logic [`EEWC_INT_LINES-1:0] eewc_int_t;
  // whole state of the controller on the system clock
  typedef struct packed {
    eewc_ext_t  rise_s1;   // rising toggle, first sync stage
    eewc_ext_t  rise_s2;   // rising toggle, second sync stage
    eewc_ext_t  rise_seen; // rising toggle already handled
    eewc_ext_t  fall_s1;   // falling toggle, first sync stage
    eewc_ext_t  fall_s2;   // falling toggle, second sync stage
    eewc_ext_t  fall_seen; // falling toggle already handled
    eewc_int_t  int_prev;  // previous level of internal sources
    eewc_line_t pend;      // pending requests
    logic       irq;       // interrupt request
    logic       evt;       // event pulse
    logic       wake;      // wakeup request
  } eewc_state_s;
endpackage

// ==== verif/eewc_src_model.sv ====
// pin and peripheral source model facing the controller
`timescale 1ns/100ps
module eewc_src_model (
  input  wire logic        sys_clk_i, // system clock
  output logic      [85:0] gpio_o,    // pin levels
  output logic      [15:0] int_src_o  // peripheral wake levels
);
  // all sources idle low from time zero
  initial begin
    gpio_o = '0;
    int_src_o = '0;
  end
  // toggle a pin twice, narrower than a clock
  task automatic pin_pulse(int p, realtime w);
    gpio_o[p] = ~gpio_o[p];
    #(w) gpio_o[p] = ~gpio_o[p];
  endtask
  // peripheral levels are synchronous, so move after the falling edge
  task automatic set_int(int i, logic v);
    @(negedge sys_clk_i);
    int_src_o[i] = v;
  endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench of the edge event wakeup controller
`timescale 1ns/100ps
module tb_top;
  import eewc_pkg::*;
  logic             sys_clk_i = 1'b0; // system clock
  logic             run       = 1'b1; // 0 halts the clock, as in stop mode
  logic             rst_i     = 1'b0; // reset, synchronous for state and asynchronous for pin toggles, raised at 1 ns
  logic [85:0]      gpio;             // pins from the model
  logic [15:0]      isrc;             // peripheral levels from the model
  logic [15:0][6:0] sel       = '0;   // pin picked per external line
  eewc_line_t       rise_en   = '0;
  eewc_line_t       fall_en   = '0;
  eewc_line_t       int_en    = '0;
  eewc_line_t       evt_en    = '0;
  eewc_line_t       clr       = '0;
  eewc_line_t       pend;
  logic             irq, evt, wake;
  int               fail_count = 0, n_compared = 0, cyc = 0, evt_seen = 0;
  // clock; a halted clock rests low
  initial forever #5 if (run) sys_clk_i = ~sys_clk_i;
  eewc_src_model u_src (.sys_clk_i(sys_clk_i), .gpio_o(gpio), .int_src_o(isrc));
  eewc_top DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .gpio_pin_i(gpio), .line_sel_i(sel),
    .rtc_wake_i(isrc[0]), .two_wire_port_one_i(isrc[1]), .serial_port_one_i(isrc[2]),
    .serial_port_two_i(isrc[3]), .usb_wake_i(isrc[4]), .analog_comparators_i(isrc[6:5]),
    .secondary_io_supply_i(isrc[7]), .cec_wake_i(isrc[8]), .spare_wake_i(isrc[15:9]),
    .rise_en_i(rise_en), .fall_en_i(fall_en), .int_en_i(int_en), .evt_en_i(evt_en),
    .pend_clr_i(clr), .pending_o(pend), .irq_o(irq), .evt_o(evt), .wakeup_o(wake));
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cycles(int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // clear by writing one, held for one edge
  task automatic clr_all();
    clr = '1;
    cycles(1);
    clr = '0;
  endtask
  // event pulses are counted where they are settled
  always @(negedge sys_clk_i) if (evt === 1'b1) evt_seen++;
  // hang guard; a halted clock does not count
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  // a 2 ns pin pulse on line 3 routed from the last pin
  task automatic t_narrow();
    sel[3] = 7'h55;
    rise_en[3] = 1'b1;
    int_en[3] = 1'b1;
    evt_en[3] = 1'b1;
    cycles(1);
    u_src.pin_pulse(85, 2.0);
    cycles(5);
    chk("pend narrow", 32'h8, pend);
    chk("irq narrow", 32'h1, irq);
    chk("wake narrow", 32'h1, wake);
    chk("evt count", 32'h1, evt_seen);
    clr_all();
    chk("pend cleared", 32'h0, pend);
    chk("flags cleared", 32'h0, {30'h0, irq, wake});
  endtask
  // rising only, falling only and both, on internal lines 17 to 19
  task automatic t_edges();
    for (int m = 1; m < 4; m++) begin
      rise_en[16+m] = m[0];
      fall_en[16+m] = m[1];
      int_en[16+m] = 1'b1;
      u_src.set_int(m, 1'b1);
      cycles(2);
      chk("rise trig", m[0], pend[16+m]);
      clr_all();
      u_src.set_int(m, 1'b0);
      cycles(2);
      chk("fall trig", m[1], pend[16+m]);
      clr_all();
    end
  endtask
  // masked comparator line gives nothing, its unmasked neighbour still fires
  task automatic t_mask();
    rise_en[21] = 1'b1;
    rise_en[22] = 1'b1;
    int_en[22] = 1'b1;
    u_src.set_int(5, 1'b1);
    u_src.set_int(6, 1'b1);
    cycles(3);
    chk("masked pend", 32'h0040_0000, pend);
    chk("masked evt", 32'h0, {31'h0, evt});
    chk("neighbour irq", 32'h1, {31'h0, irq});
    clr_all();
    chk("masked cleared", 32'h0, pend);
  endtask
  // pin falls while the clock is halted; wakeup once it runs again
  task automatic t_stop();
    sel[0] = 7'h0A;
    fall_en[0] = 1'b1;
    int_en[0] = 1'b1;
    run = 1'b0;
    #20 u_src.pin_pulse(10, 1.0);
    #50 run = 1'b1;
    cycles(5);
    chk("stop pend", 32'h1, pend);
    chk("stop wake", 32'h1, wake);
  endtask
  // main sequence
  initial begin
    // a real rising edge on reset is what clears the pin toggles
    #1 rst_i = 1'b1;
    cycles(20);
    rst_i = 1'b0;
    cycles(1);
    chk("reset pend", 32'h0, pend);
    chk("reset flags", 32'h0, {29'h0, irq, evt, wake});
    t_narrow();
    t_edges();
    t_mask();
    t_stop();
    finish_test();
  end
endmodule
